//--- logic/smsw_pkg.sv
// Purpose: shared constants for the switch monitor sleep/wake controller
// Assumes: 40 MHz core clock
// Notes:   times kept in printed units, cycle counts derived from them
package smsw_pkg;
    // =========================================================
    // geometry and sleep command fields
    localparam int NSW           = 22;
    localparam int INT_FIELD_LO  = 3;
    localparam int SCAN_FIELD_LO = 0;
    localparam int CFG_W         = 6;
    localparam logic [2:0] INT_OFF_CODE  = 3'h7;
    localparam logic [2:0] SCAN_OFF_CODE = 3'h0;
    localparam logic [5:0] CFG_RESET     = 6'h00;

    // =========================================================
    // timing
    localparam int CLK_KHZ     = 40000;
    localparam int INT_BASE_MS = 32;
    localparam int SCAN_BASE_US = 1000;
    localparam int SCAN_WIN_US = 125;
    localparam int WET_MS      = 20;
    localparam int INT_BASE_CYC  = INT_BASE_MS * CLK_KHZ;
    localparam int SCAN_BASE_CYC = SCAN_BASE_US * CLK_KHZ / 1000;
    localparam int SCAN_WIN_CYC  = SCAN_WIN_US * CLK_KHZ / 1000;
    localparam int WET_CYC       = WET_MS * CLK_KHZ;

    // =========================================================
    // operating mode
    typedef enum logic [1:0] {
        mode_normal = 2'b00,
        mode_sleep  = 2'b01,
        mode_scan   = 2'b10
    } smsw_mode_t;
endpackage : smsw_pkg

//--- logic/smsw_ctrl.sv
// Purpose: mode, sleep timers, wake sources, interrupt, wetting, thermal
// Assumes: all inputs synchronous to i_clk; switch inputs 1 = closed
// Notes:   configuration arrives as level ports held by the command decoder
`timescale 1ns/1ps

module smsw_ctrl #(
    parameter int INT_BASE_CYC  = smsw_pkg::INT_BASE_CYC,
    parameter int SCAN_BASE_CYC = smsw_pkg::SCAN_BASE_CYC,
    parameter int SCAN_WIN_CYC  = smsw_pkg::SCAN_WIN_CYC,
    parameter int WET_CYC       = smsw_pkg::WET_CYC
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_reset_n,
    input  wire logic                     i_sleep_cmd,
    input  wire logic [smsw_pkg::CFG_W-1:0] i_sleep_cfg,
    input  wire logic                     i_status_read,
    input  wire logic                     i_cs_n,
    input  wire logic                     i_wake_n,
    input  wire logic                     i_irq_line_n,
    input  wire logic                     i_vdd_ok,
    input  wire logic                     i_over_temp,
    input  wire logic [smsw_pkg::NSW-1:0] i_sw_closed,
    input  wire logic [smsw_pkg::NSW-1:0] i_wake_en,
    input  wire logic [smsw_pkg::NSW-1:0] i_metallic,
    input  wire logic [smsw_pkg::NSW-1:0] i_wet_timer_en,
    output logic                          o_sleep,
    output logic                          o_inputs_active,
    output logic                          o_irq_n,
    output logic                          o_therm_flag,
    output logic [smsw_pkg::NSW-1:0]      o_status,
    output logic [smsw_pkg::NSW-1:0]      o_high_current
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // =========================================================
    // helpers
    function automatic logic [31:0] period(input int base,
                                           input logic [2:0] code);
        period = 32'(base) << code;
    endfunction : period

    smsw_pkg::smsw_mode_t           mode_reg;
    logic [smsw_pkg::CFG_W-1:0]     cfg_reg;
    logic [31:0]                    int_cnt_reg;
    logic [31:0]                    scan_cnt_reg;
    logic [31:0]                    win_cnt_reg;
    logic                           cs_prev_reg;
    logic                           wake_prev_reg;
    logic                           irq_prev_reg;
    logic                           ack_pend_reg;
    logic                           frame_evt_reg;
    logic                           chg_frame_reg;
    logic [23:0]                    wet_cnt_reg [smsw_pkg::NSW];

    logic [2:0]                     int_code;
    logic [2:0]                     scan_code;
    logic                           asleep;
    logic                           cs_fall;
    logic                           cs_rise;
    logic                           pin_wake;
    logic                           int_expire;
    logic                           scan_expire;
    logic                           win_end;
    logic                           scan_change;
    logic                           norm_change;
    logic                           therm_evt;
    logic                           irq_set;
    logic                           wake_now;
    logic [smsw_pkg::NSW-1:0]       diff;

    assign int_code  = cfg_reg[smsw_pkg::INT_FIELD_LO +: 3];
    assign scan_code = cfg_reg[smsw_pkg::SCAN_FIELD_LO +: 3];
    assign asleep    = (mode_reg != smsw_pkg::mode_normal);
    assign cs_fall   = cs_prev_reg & ~i_cs_n;
    assign cs_rise   = ~cs_prev_reg & i_cs_n;
    assign diff      = (i_sw_closed ^ o_status) & i_wake_en;

    // =========================================================
    // wake sources
    // irq and cs edges come from the logic supply domain, so they are
    // gated by its presence rather than trusted while it is off
    assign pin_wake = (wake_prev_reg & ~i_wake_n)
        | (irq_prev_reg & ~i_irq_line_n & i_wake_n & i_vdd_ok)
        | (cs_fall & i_vdd_ok);

    assign int_expire  = asleep && int_code != smsw_pkg::INT_OFF_CODE
        && int_cnt_reg == period(INT_BASE_CYC, int_code) - 32'h0000_0001;
    assign scan_expire = (mode_reg == smsw_pkg::mode_sleep)
        && scan_code != smsw_pkg::SCAN_OFF_CODE
        && scan_cnt_reg == period(SCAN_BASE_CYC, scan_code - 3'h1)
                           - 32'h0000_0001;
    assign win_end     = (mode_reg == smsw_pkg::mode_scan)
        && win_cnt_reg == 32'(SCAN_WIN_CYC) - 32'h0000_0001;
    assign scan_change = win_end && (|diff);
    assign norm_change = !asleep && (|diff);
    assign therm_evt   = !asleep && i_over_temp && !o_therm_flag;
    assign irq_set     = norm_change | int_expire | scan_change | therm_evt;
    assign wake_now    = asleep && (pin_wake || int_expire || scan_change);

    // =========================================================
    // edge history
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cs_prev_reg   <= 1'b1;
            wake_prev_reg <= 1'b1;
            irq_prev_reg  <= 1'b1;
        end else begin
            cs_prev_reg   <= i_cs_n;
            wake_prev_reg <= i_wake_n;
            irq_prev_reg  <= i_irq_line_n;
        end
    end

    // =========================================================
    // mode
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mode_reg        <= smsw_pkg::mode_normal;
            cfg_reg         <= smsw_pkg::CFG_RESET;
            o_sleep         <= 1'b0;
            o_inputs_active <= 1'b1;
        end else begin
            case (mode_reg)
                smsw_pkg::mode_normal: begin
                    o_inputs_active <= 1'b1;
                    if (i_sleep_cmd) begin
                        cfg_reg         <= i_sleep_cfg;
                        mode_reg        <= smsw_pkg::mode_sleep;
                        o_sleep         <= 1'b1;
                        o_inputs_active <= 1'b0;
                    end
                end
                smsw_pkg::mode_sleep: begin
                    if (pin_wake || int_expire) begin
                        mode_reg        <= smsw_pkg::mode_normal;
                        o_sleep         <= 1'b0;
                        o_inputs_active <= 1'b1;
                    end else if (scan_expire) begin
                        mode_reg        <= smsw_pkg::mode_scan;
                        o_inputs_active <= 1'b1;
                    end
                end
                smsw_pkg::mode_scan: begin
                    if (pin_wake || int_expire || scan_change) begin
                        mode_reg        <= smsw_pkg::mode_normal;
                        o_sleep         <= 1'b0;
                        o_inputs_active <= 1'b1;
                    end else if (win_end) begin
                        mode_reg        <= smsw_pkg::mode_sleep;
                        o_inputs_active <= 1'b0;
                    end
                end
                default: begin
                    mode_reg        <= smsw_pkg::mode_normal;
                    o_sleep         <= 1'b0;
                    o_inputs_active <= 1'b1;
                end
            endcase
        end
    end

    sleep_entry_a: assert property (
        $past(mode_reg) == smsw_pkg::mode_normal && asleep
        |-> $past(i_sleep_cmd))
        else $error("sleep entered without a sleep command");
    cfg_hold_a: assert property (asleep |=> $stable(cfg_reg))
        else $error("configuration changed during sleep");
    cs_wake_a: assert property (
        mode_reg == smsw_pkg::mode_sleep && cs_fall && i_vdd_ok
        |=> mode_reg == smsw_pkg::mode_normal && !o_sleep)
        else $error("chip select edge did not wake");
    cs_nosupply_a: assert property (
        mode_reg == smsw_pkg::mode_sleep && !i_vdd_ok && !scan_expire
        && !int_expire && i_wake_n |=> mode_reg == smsw_pkg::mode_sleep)
        else $error("woke without supply or pin edge");

    // =========================================================
    // sleep timers; cleared whenever normal so the next sleep
    // starts each from a full period
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            int_cnt_reg <= 32'h0000_0000;
        end else if (!asleep || wake_now
                     || int_code == smsw_pkg::INT_OFF_CODE) begin
            int_cnt_reg <= 32'h0000_0000;
        end else begin
            int_cnt_reg <= int_cnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            scan_cnt_reg <= 32'h0000_0000;
            win_cnt_reg  <= 32'h0000_0000;
        end else begin
            if (mode_reg != smsw_pkg::mode_sleep || scan_expire
                || wake_now) begin
                scan_cnt_reg <= 32'h0000_0000;
            end else if (scan_code != smsw_pkg::SCAN_OFF_CODE) begin
                scan_cnt_reg <= scan_cnt_reg + 32'h0000_0001;
            end
            if (mode_reg == smsw_pkg::mode_scan && !win_end) begin
                win_cnt_reg <= win_cnt_reg + 32'h0000_0001;
            end else begin
                win_cnt_reg <= 32'h0000_0000;
            end
        end
    end

    int_off_a: assert property (
        int_code == smsw_pkg::INT_OFF_CODE |=> int_cnt_reg == 32'h0)
        else $error("interrupt timer ran while disabled");
    timers_idle_a: assert property (
        !asleep |-> int_cnt_reg == 32'h0 && scan_cnt_reg == 32'h0)
        else $error("sleep timer running in normal mode");
    scan_win_a: assert property (
        mode_reg == smsw_pkg::mode_scan |-> o_inputs_active
        && win_cnt_reg < 32'(SCAN_WIN_CYC))
        else $error("scan window overran or inputs idle");
    scan_quiet_a: assert property (
        win_end && !scan_change && !pin_wake && !int_expire
        |=> mode_reg == smsw_pkg::mode_sleep && !o_inputs_active)
        else $error("quiet scan did not return to sleep");

    // =========================================================
    // switch status: tracks inputs in normal, held from before
    // sleep and only refreshed when a scan wakes the device
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_status <= '0;
        end else if (!asleep || scan_change) begin
            o_status <= i_sw_closed;
        end
    end

    // =========================================================
    // interrupt; acknowledge takes effect at the end of the frame
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_irq_n       <= 1'b1;
            ack_pend_reg  <= 1'b0;
            frame_evt_reg <= 1'b0;
        end else begin
            if (irq_set) begin
                o_irq_n <= 1'b0;
            end else if (cs_rise && ack_pend_reg && !frame_evt_reg) begin
                o_irq_n <= 1'b1;
            end
            if (cs_rise) begin
                ack_pend_reg  <= 1'b0;
                frame_evt_reg <= 1'b0;
            end else begin
                if (i_status_read) begin
                    ack_pend_reg <= 1'b1;
                end
                if (irq_set && !i_cs_n) begin
                    frame_evt_reg <= 1'b1;
                end
            end
        end
    end

    irq_hold_a: assert property (
        !o_irq_n && !cs_rise |=> !o_irq_n)
        else $error("interrupt released without frame end");
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            chg_frame_reg <= 1'b0;
        end else if (cs_rise) begin
            chg_frame_reg <= 1'b0;
        end else if (!i_cs_n && norm_change) begin
            chg_frame_reg <= 1'b1;
        end
    end
    irq_frame_a: assert property (
        chg_frame_reg && cs_rise |=> !o_irq_n)
        else $error("interrupt released after in-frame change");

    // =========================================================
    // thermal flag: set wins over the clear on the same edge
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_therm_flag <= 1'b0;
        end else if (therm_evt) begin
            o_therm_flag <= 1'b1;
        end else if (cs_rise && !i_over_temp) begin
            o_therm_flag <= 1'b0;
        end
    end

    therm_flag_a: assert property (
        !asleep && i_over_temp |=> o_therm_flag ##0 !o_irq_n
        || $past(o_therm_flag))
        else $error("overtemp did not flag");
    therm_clear_a: assert property (
        o_therm_flag && cs_rise && i_over_temp |=> o_therm_flag)
        else $error("thermal flag cleared while hot");

    // =========================================================
    // wetting current; each input restarts its own window on change
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int i = 0; i < smsw_pkg::NSW; i++) begin
                wet_cnt_reg[i] <= 24'h00_0000;
            end
        end else begin
            for (int i = 0; i < smsw_pkg::NSW; i++) begin
                if (asleep) begin
                    wet_cnt_reg[i] <= 24'h00_0000;
                end else if (i_sw_closed[i] != o_status[i]) begin
                    wet_cnt_reg[i] <= 24'(WET_CYC);
                end else if (wet_cnt_reg[i] != 24'h00_0000) begin
                    wet_cnt_reg[i] <= wet_cnt_reg[i] - 24'h00_0001;
                end
            end
        end
    end

    // derating follows the live overtemp level, so settings come
    // back by themselves once the die cools
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_high_current <= '0;
        end else begin
            for (int i = 0; i < smsw_pkg::NSW; i++) begin
                o_high_current[i] <= !asleep && !i_over_temp
                    && i_metallic[i]
                    && (i_wet_timer_en[i] ? wet_cnt_reg[i] != 24'h0
                                          : i_sw_closed[i]);
            end
        end
    end

    derate_a: assert property (
        !asleep && i_over_temp |=> o_high_current == '0)
        else $error("high current not derated when hot");
    wet_cont_a: assert property (
        !asleep && !i_over_temp |=> ((o_high_current
        ^ $past(i_metallic & i_sw_closed)) & ~$past(i_wet_timer_en)) == '0)
        else $error("continuous wetting wrong");

    sleep_cov: cover property (!asleep ##1 asleep);
    scan_cov: cover property (win_end && !scan_change);
    int_wake_cov: cover property (int_expire ##1 !asleep);
    scan_wake_cov: cover property (scan_change ##1 !o_irq_n);
endmodule : smsw_ctrl

//--- bench/smsw_host.sv
// Purpose: host controller model on the serial side of the switch monitor
// Assumes: drives chip select and the acknowledge pulse at the falling edge
// Notes:   frames are built from begin/ack/end so a test can act mid-frame
`timescale 1ns/1ps

module smsw_host (
    input  wire logic i_clk,
    input  wire logic i_irq_n,
    output logic      o_cs_n,
    output logic      o_status_read
);
    initial begin
        o_cs_n        = 1'b1;
        o_status_read = 1'b0;
    end

    // =========================================================
    // frame pieces
    task begin_frame();
        @(negedge i_clk);
        o_cs_n = 1'b0;
    endtask : begin_frame

    // status read acknowledges the interrupt; read data is not kept, since a
    // frame that woke the device carries stale data anyway
    task ack();
        @(negedge i_clk);
        o_status_read = 1'b1;
        @(negedge i_clk);
        o_status_read = 1'b0;
    endtask : ack

    task end_frame();
        @(negedge i_clk);
        o_cs_n = 1'b1;
        @(negedge i_clk);
        @(negedge i_clk);
    endtask : end_frame

    // polled reads only see the level at read time
    task read_frame();
        begin_frame();
        ack();
        end_frame();
    endtask : read_frame
endmodule : smsw_host

//--- bench/testbench.sv
// Purpose: self-checking bench for the sleep/wake controller
// Assumes: shortened timer parameters; inputs change at the falling edge
// Notes:   timer expiries are checked inside a small latency allowance
`timescale 1ns/1ps

`define CHK(what, exp, got) begin total_checks++; \
    if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end end

module testbench;
    localparam int INT_P = 16;
    localparam int SCN_P = 4;
    localparam int WIN_P = 3;
    localparam int WET_P = 10;

    logic        i_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic        sleep_cmd = 1'b0;
    logic [5:0]  sleep_cfg = 6'h00;
    logic        wake_n = 1'b1;
    logic        irq_ext_n = 1'b1;
    logic        vdd_ok = 1'b1;
    logic        over_temp = 1'b0;
    logic [21:0] sw_closed = 22'h00_0000;
    logic [21:0] wet_en = 22'h3f_fffb;
    logic [21:0] wake_en = 22'h3f_ffff;
    logic [21:0] metal = 22'h3f_ffff;
    logic        cs_n;
    logic        status_read;
    logic        sleep_o;
    logic        active_o;
    logic        irq_n;
    logic        therm_o;
    logic [21:0] status_o;
    logic [21:0] high_o;
    int          n_mismatch = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          n;

    always #12.5 i_clk = ~i_clk;

    smsw_ctrl #(
        .INT_BASE_CYC  (INT_P),
        .SCAN_BASE_CYC (SCN_P),
        .SCAN_WIN_CYC  (WIN_P),
        .WET_CYC       (WET_P)
    ) i_dut (
        .i_clk           (i_clk),
        .i_reset_n       (i_reset_n),
        .i_sleep_cmd     (sleep_cmd),
        .i_sleep_cfg     (sleep_cfg),
        .i_status_read   (status_read),
        .i_cs_n          (cs_n),
        .i_wake_n        (wake_n),
        .i_irq_line_n    (irq_n & irq_ext_n),
        .i_vdd_ok        (vdd_ok),
        .i_over_temp     (over_temp),
        .i_sw_closed     (sw_closed),
        .i_wake_en       (wake_en),
        .i_metallic      (metal),
        .i_wet_timer_en  (wet_en),
        .o_sleep         (sleep_o),
        .o_inputs_active (active_o),
        .o_irq_n         (irq_n),
        .o_therm_flag    (therm_o),
        .o_status        (status_o),
        .o_high_current  (high_o)
    );

    smsw_host i_host (
        .i_clk         (i_clk),
        .i_irq_n       (irq_n),
        .o_cs_n        (cs_n),
        .o_status_read (status_read)
    );

    // =========================================================
    // helpers
    task end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task cycles(input int k);
        repeat (k) @(negedge i_clk);
    endtask : cycles

    task do_sleep(input logic [5:0] cfg);
        @(negedge i_clk);
        sleep_cmd = 1'b1;
        sleep_cfg = cfg;
        @(negedge i_clk);
        sleep_cmd = 1'b0;
        `CHK("sleep entered", 1'b1, sleep_o)
    endtask : do_sleep

    // bounded wait for the device to leave sleep
    task wait_wake(input int lim);
        n = 0;
        while (sleep_o !== 1'b0 && n < lim) begin
            @(negedge i_clk);
            n++;
        end
    endtask : wait_wake

    // hang guard: the whole sequence needs a few thousand cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // =========================================================
    // main sequence
    initial begin
        cycles(5);
        i_reset_n = 1'b1;
        cycles(2);
        `CHK("irq idle", 1'b1, irq_n)
        `CHK("normal after reset", 1'b0, sleep_o)
        $display("test reset done");

        sw_closed[0] = 1'b1;
        cycles(2);
        `CHK("irq on close", 1'b0, irq_n)
        `CHK("status closed", 1'b1, status_o[0])
        `CHK("wetting on", 1'b1, high_o[0])
        cycles(WET_P + 2);
        `CHK("wetting timed out", 1'b0, high_o[0])
        `CHK("irq held", 1'b0, irq_n)
        i_host.read_frame();
        `CHK("irq released", 1'b1, irq_n)
        sw_closed[0] = 1'b0;
        cycles(2);
        `CHK("irq on open", 1'b0, irq_n)
        `CHK("status open", 1'b0, status_o[0])
        i_host.read_frame();
        wake_en[4] = 1'b0;
        metal[4] = 1'b0;
        sw_closed[4] = 1'b1;
        cycles(2);
        `CHK("masked no irq", 1'b1, irq_n)
        `CHK("masked status", 1'b1, status_o[4])
        `CHK("low current", 1'b0, high_o[4])
        $display("test change done");

        i_host.begin_frame();
        i_host.ack();
        sw_closed[1] = 1'b1;
        i_host.end_frame();
        `CHK("irq kept", 1'b0, irq_n)
        i_host.read_frame();
        `CHK("irq cleared", 1'b1, irq_n)
        $display("test closure in frame done");

        sw_closed[2] = 1'b1;
        cycles(WET_P + 4);
        `CHK("continuous wetting", 1'b1, high_o[2])
        i_host.read_frame();
        over_temp = 1'b1;
        cycles(2);
        `CHK("thermal flag", 1'b1, therm_o)
        `CHK("derated", 22'h00_0000, high_o)
        `CHK("thermal irq", 1'b0, irq_n)
        i_host.read_frame();
        `CHK("flag kept hot", 1'b1, therm_o)
        over_temp = 1'b0;
        i_host.read_frame();
        `CHK("flag cleared", 1'b0, therm_o)
        `CHK("current restored", 1'b1, high_o[2])
        $display("test thermal done");

        do_sleep(6'h38);
        cycles(200);
        `CHK("no timer wake", 1'b1, sleep_o)
        `CHK("inputs tristate", 1'b0, active_o)
        wake_n = 1'b0;
        wait_wake(4);
        wake_n = 1'b1;
        `CHK("wake pin", 1'b0, sleep_o)
        `CHK("no irq on pin wake", 1'b1, irq_n)
        for (int c = 0; c < 7; c++) begin
            do_sleep({c[2:0], 3'h0});
            wait_wake((INT_P << c) + 4);
            `CHK("int period", 1'b1, 1'(n >= (INT_P << c) - 2))
            `CHK("int wake", 1'b0, sleep_o)
            `CHK("int irq", 1'b0, irq_n)
            i_host.read_frame();
        end
        $display("test interrupt timer done");

        for (int c = 1; c < 8; c++) begin
            do_sleep({3'h7, c[2:0]});
            n = 0;
            while (active_o !== 1'b1 && n < 300) begin
                @(negedge i_clk);
                n++;
            end
            `CHK("scan period", 1'b1, 1'((n >= (SCN_P << (c - 1)) - 2)
                && (n <= (SCN_P << (c - 1)) + 2)))
            `CHK("scan asleep", 1'b1, sleep_o)
            cycles(WIN_P + 2);
            `CHK("back to tristate", 1'b0, active_o)
            `CHK("still asleep", 1'b1, sleep_o)
            sw_closed[3] = (c == 7);
            wait_wake((SCN_P << (c - 1)) + WIN_P + 4);
            `CHK("scan wake", c == 7 ? 1'b0 : 1'b1, sleep_o)
            wake_n = 1'b0;
            cycles(3);
            wake_n = 1'b1;
        end
        `CHK("scan irq", 1'b0, irq_n)
        `CHK("scan status", 1'b1, status_o[3])
        i_host.read_frame();
        $display("test scan timer done");

        vdd_ok = 1'b0;
        do_sleep(6'h38);
        irq_ext_n = 1'b0;
        i_host.begin_frame();
        cycles(6);
        `CHK("no wake unpowered", 1'b1, sleep_o)
        i_host.end_frame();
        irq_ext_n = 1'b1;
        vdd_ok = 1'b1;
        cycles(2);
        i_host.begin_frame();
        wait_wake(5);
        `CHK("cs wake", 1'b0, sleep_o)
        i_host.end_frame();
        do_sleep(6'h38);
        irq_ext_n = 1'b0;
        wait_wake(5);
        irq_ext_n = 1'b1;
        `CHK("irq line wake", 1'b0, sleep_o)
        $display("test wake sources done");
        end_of_test();
    end
endmodule : testbench
